// file: verilog/motor_pwm_chopper_setup.sv
// motor pwm counter, chopper, blanking window and preload registers
// assumes a classic wishbone master and a same-clock commutation pulse
`timescale 1ns/1ns

// Overview of operation
// RULE1: blank demag detect after commutation, sensorless only
// RULE2: status bit shows synced bemf comparator
// RULE3: status bit shows synced current comparator
// RULE4: route bit selects current comparator source
// RULE5: chopper mode gates low, high or both
// RULE6: three bits select chopper frequency
// RULE7: chopper wave has equal high, low
// RULE8: extension bit from compare or full-duty
// RULE9: full-duty forces 100%, self-clears at update
// RULE10: alignment bit picks edge or center counting
// RULE11: prescaler divides by field plus one
// RULE12: repetition zero transfers preloads, flags update
// RULE13: update every N+1 periods or halves
// RULE14: clock enable loads repetition, flags update
// RULE15: low compare bits 2:0 reserved zero
// RULE16: period compare resets 0FFFh, 12 bits
// RULE17: software writes both compare bytes first
// RULE18: reads return active, not pending, values
// RULE19: commutation transfers other preloads together; the code moves only the phase preload
// RULE20: any dead-time write locks its field
// RULE21: software writes write-once bits first
// RULE22: dead-time reset FFh, channel count gates
// RULE23: direct mode phase write is commutation
// RULE24: center mode counts up then down
module motor_pwm_chopper_setup
  import motor_pwm_pkg::*;
#(
  parameter int DEMAG_STEP = DEMAG_STEP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  input  wire logic        commEventIn,
  input  wire logic        bemfCompIn,
  input  wire logic        currentCompIn,
  output      logic [2:0]  pwmOut,
  output      logic        updateIrq,
  output      logic        demagBlank,
  output      logic        currentRouteSel,
  output      logic        chopHighGate,
  output      logic        chopLowGate,
  output      logic [7:0]  phaseStateOut,
  output      logic [7:0]  deadTimeSetup
);

  localparam st_t ST_RST = '{perPre: PER_RST, perAct: PER_RST,
                             dead_time_value: DTG_RST, dir: DIR_UP, default: '0};
  localparam logic [15:0] STEP_LAST = 16'(DEMAG_STEP - 1);

  // ==========================================================
  // reset release
  logic [1:0] rstPipe;
  logic       rstSync;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rstPipe <= 2'b00;
    else        rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync = rstPipe[1];

  // ==========================================================
  // register read, active values only
  function automatic logic [7:0] regRead(input st_t s,
                                         input logic [7:0] a);
    if (a == OFF_REF)
      regRead = {s.bemfLvl, s.curLvl, s.refCtl}; // RULE2 RULE3
    else if (a == OFF_PCR)  regRead = s.pcr;
    else if (a == OFF_REP)  regRead = s.repAct; // RULE18
    else if (a == OFF_PHASE_W_HIGH_BITS) regRead = s.cmpAct[2][15:8];
    else if (a == OFF_PHASE_W_LOW_BITS) regRead = {s.cmpAct[2][7:3], 3'h0}; // RULE15
    else if (a == OFF_PHASE_V_HIGH_BITS) regRead = s.cmpAct[1][15:8];
    else if (a == OFF_PHASE_V_LOW_BITS) regRead = {s.cmpAct[1][7:3], 3'h0};
    else if (a == OFF_PHASE_U_HIGH_BITS) regRead = s.cmpAct[0][15:8];
    else if (a == OFF_PHASE_U_LOW_BITS) regRead = {s.cmpAct[0][7:3], 3'h0};
    else if (a == OFF_P0H)  regRead = {4'h0, s.perAct[11:8]}; // RULE16
    else if (a == OFF_P0L)  regRead = s.perAct[7:0];
    else if (a == OFF_DTG)  regRead = s.dead_time_value;
    else if (a == OFF_CTL)  regRead = s.ctrl;
    else if (a == OFF_PHS)  regRead = s.phAct; // RULE18
    else                    regRead = 8'h00;
  endfunction : regRead

  st_t         s;
  st_t         n;
  logic        cke;
  logic        tick;
  logic        perEv;
  logic        updEv;
  logic        req;
  logic        wr;
  logic        wrPh;
  logic        commEv;
  logic        w8;
  logic        full;
  logic [11:0] mag;
  logic [7:0]  wd;

  // ==========================================================
  // next state
  always_comb begin
    n      = s;
    n.upd  = 1'b0;
    tick   = 1'b0;
    perEv  = 1'b0;
    updEv  = 1'b0;
    wrPh   = 1'b0;
    full   = 1'b0;
    mag    = 12'h000;
    wd     = wb_dat_i[7:0];
    cke    = s.ctrl[CTL_CKE_BIT];
    w8     = s.pcr[PCR_W8_BIT];
    n.ckePrev = cke;

    n.bemfS = {s.bemfS[1:0], bemfCompIn};
    n.curS  = {s.curS[1:0], currentCompIn};
    if (s.bemfS[1] == s.bemfS[2]) n.bemfLvl = s.bemfS[2]; // RULE2
    if (s.curS[1] == s.curS[2])   n.curLvl = s.curS[2]; // RULE3

    // pwm counter
    if (!cke) begin
      n.pre = 3'h0;
      n.cnt = 12'h000;
      n.dir = DIR_UP;
    end else begin
      tick  = s.pre == s.pcr[2:0]; // RULE11
      n.pre = tick ? 3'h0 : s.pre + 3'h1;
      if (tick) begin
        if (!s.pcr[PCR_CMS_BIT]) begin // RULE10
          perEv = s.cnt >= s.perAct;
          n.cnt = perEv ? 12'h000 : s.cnt + 12'h001;
        end else if (s.dir == DIR_UP) begin // RULE24
          perEv = s.cnt >= s.perAct;
          if (perEv) n.dir = DIR_DOWN;
          else       n.cnt = s.cnt + 12'h001;
        end else begin
          perEv = s.cnt == 12'h000;
          if (perEv) n.dir = DIR_UP;
          else       n.cnt = s.cnt - 12'h001;
        end
      end
    end

    // repetition and update
    if (perEv) begin // RULE13
      if (s.repCnt == 8'h00) updEv = 1'b1;
      else                   n.repCnt = s.repCnt - 8'h01;
    end
    if (cke && !s.ckePrev) begin // RULE14
      n.repAct = s.repPre;
      n.repCnt = s.repPre;
      n.upd    = 1'b1;
    end
    if (updEv) begin // RULE12
      n.upd     = 1'b1;
      n.repAct  = s.repPre;
      n.repCnt  = s.repPre;
      n.cmpAct  = s.cmpPre;
      n.perAct  = s.perPre;
      n.fullAct = {s.pcr[PCR_FW_BIT], s.pcr[PCR_FV_BIT],
                   s.pcr[PCR_FU_BIT]};
      n.pcr[PCR_FU_BIT:PCR_FW_BIT] = 3'h0; // RULE9
    end

    // phase outputs
    for (int i = 0; i < 3; i++) begin
      full = s.fullAct[i] | (!w8 & s.cmpAct[i][15]); // RULE8 RULE9
      mag  = w8 ? {s.cmpAct[i][15:8], 4'h0} : s.cmpAct[i][14:3];
      n.pwm[i] = cke & (full | (s.cnt < mag));
      if (i > 0) n.pwm[i] = n.pwm[i] & s.dead_time_value[DTG_PCN_BIT]; // RULE22
    end

    // chopper
    if (s.refCtl[4:3] == 2'h0) begin
      n.chopCnt = 9'h000;
      n.chop    = 1'b0;
    end else if (s.chopCnt >= chopHalf(s.refCtl[2:0]) - 9'h001) begin
      n.chopCnt = 9'h000; // RULE6
      n.chop    = !s.chop; // RULE7
    end else begin
      n.chopCnt = s.chopCnt + 9'h001;
    end
    n.chopHi = !s.refCtl[4] | s.chop; // RULE5
    n.chopLo = !s.refCtl[3] | s.chop;

    // bus slave
    req   = wb_cyc_i & wb_stb_i & !s.ack;
    wr    = req & wb_we_i & wb_sel_i[0];
    n.ack = req;
    if (req) n.rdat = regRead(s, wb_adr_i);
    if (wr) begin
      if (wb_adr_i == OFF_REF)       n.refCtl = wd[5:0];
      else if (wb_adr_i == OFF_PCR)  n.pcr = wd;
      else if (wb_adr_i == OFF_REP)  n.repPre = wd;
      else if (wb_adr_i == OFF_PHASE_W_HIGH_BITS) n.cmpPre[2][15:8] = wd; // RULE17
      else if (wb_adr_i == OFF_PHASE_W_LOW_BITS) n.cmpPre[2][7:3] = wd[7:3];
      else if (wb_adr_i == OFF_PHASE_V_HIGH_BITS) n.cmpPre[1][15:8] = wd;
      else if (wb_adr_i == OFF_PHASE_V_LOW_BITS) n.cmpPre[1][7:3] = wd[7:3];
      else if (wb_adr_i == OFF_PHASE_U_HIGH_BITS) n.cmpPre[0][15:8] = wd;
      else if (wb_adr_i == OFF_PHASE_U_LOW_BITS) n.cmpPre[0][7:3] = wd[7:3];
      else if (wb_adr_i == OFF_P0H)  n.perPre[11:8] = wd[3:0];
      else if (wb_adr_i == OFF_P0L)  n.perPre[7:0] = wd;
      else if (wb_adr_i == OFF_DTG) begin
        n.dead_time_value[7:6] = wd[7:6];
        if (!s.dtLock) n.dead_time_value[5:0] = wd[5:0]; // RULE20
        n.dtLock = 1'b1;
      end else if (wb_adr_i == OFF_CTL) n.ctrl = wd;
      else if (wb_adr_i == OFF_PHS) begin
        n.phPre = wd;
        wrPh    = 1'b1;
      end
    end

    // commutation and blanking
    commEv = s.ctrl[CTL_DAC_BIT] ? wrPh : commEventIn; // RULE23
    if (commEv) n.phAct = n.phPre; // RULE19
    if (s.ctrl[CTL_SR_BIT]) begin
      n.blank = 1'b0; // RULE1
    end else if (commEv) begin
      n.blank      = 1'b1;
      n.blankSub   = 16'h0000;
      n.blankUnits = demagUnits(s.ctrl[7:4]);
    end else if (s.blank) begin
      n.blankSub = s.blankSub + 16'h0001;
      if (s.blankSub == STEP_LAST) begin
        n.blankSub   = 16'h0000;
        n.blankUnits = s.blankUnits - 6'h01;
        if (s.blankUnits == 6'h01) n.blank = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) s <= ST_RST;
    else          s <= n;
  end

  assign wb_dat_o        = {24'h000000, s.rdat};
  assign wb_ack_o        = s.ack;
  assign pwmOut          = s.pwm;
  assign updateIrq       = s.upd;
  assign demagBlank      = s.blank;
  assign currentRouteSel = s.refCtl[REF_ROUTE_BIT]; // RULE4
  assign chopHighGate    = s.chopHi;
  assign chopLowGate     = s.chopLo;
  assign phaseStateOut   = s.phAct;
  assign deadTimeSetup   = s.dead_time_value;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync);

  property p_blank_start;
    commEv && !s.ctrl[CTL_SR_BIT] |=> demagBlank;
  endproperty
  a_blank_start: assert property (p_blank_start) // RULE1
    else $error("blanking did not start");

  property p_blank_sensor;
    s.ctrl[CTL_SR_BIT] |=> !demagBlank;
  endproperty
  a_blank_sensor: assert property (p_blank_sensor) // RULE1
    else $error("blanking in sensor mode");

  property p_bemf;
    s.bemfS[1] == s.bemfS[2] |=> s.bemfLvl == $past(s.bemfS[2]);
  endproperty
  a_bemf: assert property (p_bemf) // RULE2
    else $error("bemf level not tracking");

  property p_low_rsv;
    req && !wb_we_i && wb_adr_i == OFF_PHASE_U_LOW_BITS |=> wb_dat_o[2:0] == 3'h0;
  endproperty
  a_low_rsv: assert property (p_low_rsv) // RULE15
    else $error("reserved low bits nonzero");

  property p_full;
    s.fullAct[0] && s.ctrl[CTL_CKE_BIT] |=> pwmOut[0];
  endproperty
  a_full: assert property (p_full) // RULE9
    else $error("full duty not applied");

  property p_lock;
    s.dtLock && wr && wb_adr_i == OFF_DTG |=> $stable(s.dead_time_value[5:0]);
  endproperty
  a_lock: assert property (p_lock) // RULE20
    else $error("write-once field changed");

  property p_pcn;
    !s.dead_time_value[DTG_PCN_BIT] |=> pwmOut[2:1] == 2'b00;
  endproperty
  a_pcn: assert property (p_pcn) // RULE22
    else $error("v/w passed with one channel");

  property p_rep;
    updEv |=> updateIrq && s.repCnt == s.repAct;
  endproperty
  a_rep: assert property (p_rep) // RULE12
    else $error("repetition reload wrong");

  property p_dac;
    s.ctrl[CTL_DAC_BIT] && wrPh |=> phaseStateOut == $past(wd);
  endproperty
  a_dac: assert property (p_dac) // RULE23
    else $error("direct write not applied");

  property p_edge;
    tick && !s.pcr[PCR_CMS_BIT] && s.cnt >= s.perAct |=> s.cnt == 12'h000;
  endproperty
  a_edge: assert property (p_edge) // RULE10
    else $error("edge counter did not wrap");

  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack longer than one cycle");

  c_update: cover property (updEv);
  c_blank: cover property (commEv ##1 demagBlank);
  c_center: cover property (s.dir == DIR_DOWN && tick);
  c_chop: cover property ($rose(s.chop));

endmodule : motor_pwm_chopper_setup

// file: verilog/motor_pwm_pkg.sv
// motor pwm / chopper setup: offsets, fields, reset values, timing
// assumes a 50 MHz sys_clk and byte addresses on a 32-bit wishbone
package motor_pwm_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_REF  = 8'h00;
  localparam logic [7:0] OFF_PCR  = 8'h04;
  localparam logic [7:0] OFF_REP  = 8'h08;
  localparam logic [7:0] OFF_PHASE_W_HIGH_BITS = 8'h0C;
  localparam logic [7:0] OFF_PHASE_W_LOW_BITS = 8'h10;
  localparam logic [7:0] OFF_PHASE_V_HIGH_BITS = 8'h14;
  localparam logic [7:0] OFF_PHASE_V_LOW_BITS = 8'h18;
  localparam logic [7:0] OFF_PHASE_U_HIGH_BITS = 8'h1C;
  localparam logic [7:0] OFF_PHASE_U_LOW_BITS = 8'h20;
  localparam logic [7:0] OFF_P0H  = 8'h24;
  localparam logic [7:0] OFF_P0L  = 8'h28;
  localparam logic [7:0] OFF_DTG  = 8'h2C;
  localparam logic [7:0] OFF_CTL  = 8'h30;
  localparam logic [7:0] OFF_PHS  = 8'h34;

  // ==========================================================
  // field positions
  localparam int REF_BEMF_BIT  = 7;
  localparam int REF_CUR_BIT   = 6;
  localparam int REF_ROUTE_BIT = 5;
  localparam int PCR_W8_BIT    = 7;
  localparam int PCR_FU_BIT    = 6;
  localparam int PCR_FV_BIT    = 5;
  localparam int PCR_FW_BIT    = 4;
  localparam int PCR_CMS_BIT   = 3;
  localparam int DTG_PCN_BIT   = 7;
  localparam int CTL_CKE_BIT   = 0;
  localparam int CTL_SR_BIT    = 1;
  localparam int CTL_DAC_BIT   = 2;

  // ==========================================================
  // reset values
  localparam logic [11:0] PER_RST = 12'hFFF;
  localparam logic [7:0]  DTG_RST = 8'hFF;

  // ==========================================================
  // timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int DEMAG_STEP_NS = 5000;
  localparam int DEMAG_STEP_CYC = DEMAG_STEP_NS / (1_000_000_000 / CLK_HZ);

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_t;

  typedef struct packed {
    logic             ack;
    logic [7:0]       rdat;
    logic [5:0]       refCtl;
    logic [7:0]       pcr;
    logic [7:0]       repPre;
    logic [7:0]       repAct;
    logic [7:0]       repCnt;
    logic [2:0][15:0] cmpPre;
    logic [2:0][15:0] cmpAct;
    logic [2:0]       fullAct;
    logic [11:0]      perPre;
    logic [11:0]      perAct;
    logic [7:0]       dead_time_value;
    logic             dtLock;
    logic [7:0]       ctrl;
    logic [7:0]       phPre;
    logic [7:0]       phAct;
    logic             ckePrev;
    logic [2:0]       pre;
    logic [11:0]      cnt;
    dir_t             dir;
    logic [8:0]       chopCnt;
    logic             chop;
    logic             chopHi;
    logic             chopLo;
    logic [15:0]      blankSub;
    logic [5:0]       blankUnits;
    logic             blank;
    logic             upd;
    logic [2:0]       pwm;
    logic [2:0]       bemfS;
    logic [2:0]       curS;
    logic             bemfLvl;
    logic             curLvl;
  } st_t;

  // chopper half period in sys_clk cycles
  function automatic logic [8:0] chopHalf(input logic [2:0] f);
    case (f)
      3'h0:    chopHalf = 9'(CLK_HZ / 200_000);
      3'h1:    chopHalf = 9'(CLK_HZ / 400_000);
      3'h2:    chopHalf = 9'(CLK_HZ / 800_000);
      3'h3:    chopHalf = 9'(CLK_HZ / 1_000_000);
      3'h4:    chopHalf = 9'(CLK_HZ / 1_600_000);
      3'h5:    chopHalf = 9'(CLK_HZ / 2_000_000);
      3'h6:    chopHalf = 9'(CLK_HZ / 2_666_666);
      default: chopHalf = 9'(CLK_HZ / 4_000_000);
    endcase
  endfunction : chopHalf

  // blanking length in 5 us units
  function automatic logic [5:0] demagUnits(input logic [3:0] c);
    if (!c[3]) demagUnits = {2'h0, c} + 6'h01;
    else       demagUnits = {c, 2'h0} - 6'h14;
  endfunction : demagUnits

endpackage : motor_pwm_pkg

// file: test/motor_inverter_model.sv
// stand-in for the inverter, gate drivers and analog comparators
// assumes one clock shared with the block; commReq is a one-cycle request
`timescale 1ns/1ns
module motor_inverter_model (
  input  wire logic       sys_clk,
  input  wire logic [2:0] pwmOut,
  input  wire logic       chopHighGate,
  input  wire logic       chopLowGate,
  input  wire logic       commReq,
  input  wire logic       bemfSet,
  input  wire logic       curSet,
  output      logic       commEventIn,
  output      logic       bemfCompIn,
  output      logic       currentCompIn
);
  initial begin
    commEventIn = 1'b0;
    bemfCompIn = 1'b0;
    currentCompIn = 1'b0;
  end
  // commutation pulse lasts one cycle; comparators follow the analog level
  always @(posedge sys_clk) begin
    commEventIn <= commReq;
    bemfCompIn <= bemfSet;
    currentCompIn <= curSet;
  end
endmodule : motor_inverter_model

// file: test/test_motor_pwm_chopper_setup.sv
// bench for the pwm counter, chopper, blanking and preload registers
// assumes motor_pwm_pkg and the inverter model on the output side
`timescale 1ns/1ns
module test_motor_pwm_chopper_setup;
  import motor_pwm_pkg::*;
  localparam int STEP = 4;
  logic        sysClk, rstN, wbCyc, wbStb, wbWe, wbAck;
  logic [7:0]  wbAdr, ph, phase, dtOut;
  logic [31:0] wbDi, wbDo;
  logic [2:0]  pwmOut;
  logic        comm, bemf, cur, commReq, bemfSet, curSet;
  logic        upd, blank, route, chopHi, chopLo;
  int          fails, total_checks, n, hi, vw, p, repetition_value, oldRep, per, mag, f, g;
  int          updCnt, runLen, runMax;

  // ==========================================================
  // clock, design and partner
  initial begin
    sysClk = 1'b0;
    forever #10 sysClk = ~sysClk;
  end
  motor_pwm_chopper_setup #(.DEMAG_STEP(STEP)) dut (
    .sys_clk(sysClk), .rst_n(rstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDi),
    .wb_dat_o(wbDo), .wb_ack_o(wbAck), .commEventIn(comm),
    .bemfCompIn(bemf), .currentCompIn(cur), .pwmOut(pwmOut),
    .updateIrq(upd), .demagBlank(blank), .currentRouteSel(route),
    .chopHighGate(chopHi), .chopLowGate(chopLo), .phaseStateOut(phase),
    .deadTimeSetup(dtOut));
  motor_inverter_model partner (
    .sys_clk(sysClk), .pwmOut(pwmOut), .chopHighGate(chopHi),
    .chopLowGate(chopLo), .commReq(commReq), .bemfSet(bemfSet),
    .curSet(curSet), .commEventIn(comm), .bemfCompIn(bemf),
    .currentCompIn(cur));

  // update pulses, counted mid-cycle so the main process sees a settled sum
  always @(negedge sysClk) updCnt += int'(upd === 1'b1);

  // ==========================================================
  // expectations and helpers
  function automatic logic sigSel(input int s);
    case (s)
      0:       sigSel = upd;
      1:       sigSel = blank;
      2:       sigSel = chopLo;
      default: sigSel = chopHi;
    endcase
  endfunction : sigSel
  function automatic int chopExp(input int fs);
    int hz[8] = '{100000, 200000, 400000, 500000, 800000, 1000000,
                  1333333, 2000000};
    chopExp = 25_000_000 / hz[fs];
  endfunction : chopExp
  function automatic int blankExp(input int c);
    blankExp = STEP * ((c < 8) ? c + 1 : 4 * c - 20);
  endfunction : blankExp
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic tmo;
    fails++;
    $display("MISMATCH %0t wait ran out", $time);
    final_report();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t value %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic chkN(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chkN
  // one classic cycle; entered just after a rising edge
  task automatic wbx(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int k;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDi <= {24'h0, d};
    k = 0;
    do begin
      @(posedge sysClk);
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    if (k >= 20) tmo();
    q = wbDo[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge sysClk);
  endtask : wbx
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    wbx(1'b1, a, d, x);
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    wbx(1'b0, a, 8'h00, x);
    chk(32'(x), 32'(e));
  endtask : rdChk
  // counts edges until the chosen output shows v; tallies phase levels
  task automatic waitFor(input int s, input logic v, output int cnt);
    cnt = 0;
    hi = 0;
    vw = 0;
    runMax = 0;
    do begin
      @(posedge sysClk);
      cnt++;
      hi += int'(pwmOut[0] === 1'b1);
      vw += int'(pwmOut[2:1] !== 2'b00);
      runLen = (pwmOut[0] === 1'b1) ? runLen + 1 : 0;
      if (runLen > runMax) runMax = runLen;
    end while (sigSel(s) !== v && cnt < 20000);
    if (cnt >= 20000) tmo();
  endtask : waitFor
  task automatic pulseComm;
    commReq <= 1'b1;
    @(posedge sysClk);
    commReq <= 1'b0;
  endtask : pulseComm

  // ==========================================================
  // main sequence
  initial begin
    fails = 0;
    total_checks = 0;
    rstN = 1'b0;
    {wbCyc, wbStb, wbWe, commReq, bemfSet, curSet} = 6'h00;
    wbAdr = 8'h00;
    wbDi = 32'h0;
    void'($urandom(32'hBA19));
    repeat (5) @(posedge sysClk);
    rstN <= 1'b1;
    repeat (3) @(posedge sysClk);
    // dead-time register is left untouched until its first write
    for (int i = 0; i < 11; i++)
      rdChk(8'(4 * i), (i == 9) ? 8'h0F : (i > 9) ? 8'hFF : 8'h00);
    chk(32'(dtOut), 32'hFF);
    wr(8'hFC, 8'h55);
    rdChk(8'hFC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bemfSet <= i[1];
      curSet <= i[0];
      repeat (6) @(posedge sysClk);
      wr(OFF_REF, {2'b00, i[0], 5'h00});
      chk(32'(route), 32'(i[0]));
      rdChk(OFF_REF, {i[1], i[0], i[0], 5'h00});
    end
    for (int m = 1; m < 4; m++) begin
      f = $urandom_range(7);
      g = (m == 2) ? 3 : 2;
      wr(OFF_REF, 8'((m << 3) | f));
      waitFor(g, 1'b1, n);
      waitFor(g, 1'b0, n);
      waitFor(g, 1'b1, n);
      chkN(n, chopExp(f));
      waitFor(g, 1'b0, n);
      chkN(n, chopExp(f));
      if (m != 3) chk(32'(sigSel(5 - g)), 32'h1);
    end
    wr(OFF_REF, 8'h07);
    repeat (3) @(posedge sysClk);
    chk(32'({chopHi, chopLo}), 32'h3);
    for (int c = 0; c < 17; c++) begin
      wr(OFF_CTL, 8'(((c % 16) << 4) | ((c / 16) << CTL_SR_BIT)));
      pulseComm();
      if (c < 16) begin
        waitFor(1, 1'b1, n);
        waitFor(1, 1'b0, n);
        chkN(n, blankExp(c));
      end
    end
    repeat (4) @(posedge sysClk);
    chk(32'(blank), 32'h0);
    ph = 8'($urandom);
    wr(OFF_CTL, 8'(1 << CTL_DAC_BIT));
    wr(OFF_PHS, ph);
    chk(32'(phase), 32'(ph));
    wr(OFF_CTL, 8'h00);
    wr(OFF_PHS, ~ph);
    rdChk(OFF_PHS, ph);
    pulseComm();
    repeat (2) @(posedge sysClk);
    rdChk(OFF_PHS, ~ph);
    per = $urandom_range(8, 40);
    mag = $urandom_range(1, 7);
    wr(OFF_CTL, 8'(1 << CTL_CKE_BIT));
    chkN(updCnt, 1);
    // first period after enable, then one steady reset-value period
    waitFor(0, 1'b1, n);
    waitFor(0, 1'b1, n);
    chkN(n, 4096);
    wr(OFF_P0H, 8'h00);
    wr(OFF_P0L, 8'(per));
    wr(OFF_PHASE_V_HIGH_BITS, 8'h40);
    wr(OFF_PHASE_V_LOW_BITS, 8'h00);
    wr(OFF_PHASE_W_HIGH_BITS, 8'h40);
    wr(OFF_PHASE_W_LOW_BITS, 8'h00);
    wr(OFF_PHASE_U_HIGH_BITS, 8'h00);
    wr(OFF_PHASE_U_LOW_BITS, 8'((mag << 3) | 7));
    rdChk(OFF_PHASE_U_LOW_BITS, 8'h00);
    waitFor(0, 1'b1, n);
    rdChk(OFF_PHASE_U_LOW_BITS, 8'(mag << 3));
    oldRep = 0;
    for (int m = 0; m < 2; m++) begin
      p = $urandom_range(7);
      repetition_value = m + $urandom_range(3 - m);
      wr(OFF_PCR, 8'((m << PCR_CMS_BIT) | p));
      wr(OFF_REP, 8'(repetition_value));
      rdChk(OFF_REP, 8'(oldRep));
      waitFor(0, 1'b1, n);
      waitFor(0, 1'b1, n);
      waitFor(0, 1'b1, n);
      chkN(n, (repetition_value + 1) * (per + 1) * (p + 1));
      if (m == 0) chkN(hi, (repetition_value + 1) * mag * (p + 1));
      chkN(runMax, (m + 1) * mag * (p + 1));
      oldRep = repetition_value;
    end
    wr(OFF_PCR, 8'(1 << PCR_FU_BIT));
    waitFor(0, 1'b1, n);
    rdChk(OFF_PCR, 8'h00);
    waitFor(0, 1'b1, n);
    chkN(hi, n);
    waitFor(0, 1'b1, n);
    waitFor(0, 1'b1, n);
    chkN(hi, (repetition_value + 1) * mag);
    // 8-bit mode: the low compare byte no longer counts
    wr(OFF_PCR, 8'(1 << PCR_W8_BIT));
    waitFor(0, 1'b1, n);
    waitFor(0, 1'b1, n);
    chkN(hi, 0);
    wr(OFF_DTG, 8'h45);
    rdChk(OFF_DTG, 8'h45);
    wr(OFF_DTG, 8'h2A);
    rdChk(OFF_DTG, 8'h05);
    chk(32'(dtOut), 32'h05);
    waitFor(0, 1'b1, n);
    waitFor(0, 1'b1, n);
    chkN(vw, 0);
    final_report();
  end
endmodule : test_motor_pwm_chopper_setup
